/* rtl/asfo_core.sv */
// Execution unit for word subtract with borrow, carry set, space select, arithmetic
// shifts, test-and-complement under mask and pointer loads, behind a Wishbone slave.
// Assumes a classic Wishbone master on the same 20 MHz clock; no pin inputs.
`timescale 1ns/1ps
`default_nettype none
module asfo_core import asfo_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire asfo_wb_req_t wb_req,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  output logic space_select_flag,
  output logic access_data_space,
  output logic [15:0] access_addr,
  output logic [7:0] page_pointer,
  output logic busy,
  output logic done
);

  asfo_core_t r_reg;
  asfo_core_t r_next;

  logic req_hit;
  logic wr_take;
  logic start;
  asfo_op_t start_op;
  asfo_mode_t start_mode;
  logic op_ok;
  logic t_busy;
  logic t_last;
  logic [16:0] sub_w;
  logic [7:0] tcm_w;
  logic [7:0] sh8_res;
  logic sh8_c;
  logic sh8_v;
  logic [15:0] sh16_res;
  logic sh16_c;
  logic sh16_v;
  logic [15:0] step_w;
  logic [15:0] start_step;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [5:0] op_cycles(input asfo_op_t op);
    logic [5:0] cyc;
    unique case (op)
      ASFO_OP_WORD_SUB_BORROW: cyc = ASFO_CYC_WORD_SUB;
      ASFO_OP_WORD_SHL: cyc = ASFO_CYC_WORD_SHL;
      ASFO_OP_STACK_FLOW: cyc = ASFO_CYC_STACK;
      default: cyc = ASFO_CYC_SHORT;
    endcase
    return cyc;
  endfunction

  function automatic logic is_word(input asfo_op_t op);
    return op == ASFO_OP_WORD_SUB_BORROW || op == ASFO_OP_WORD_SHL ||
           op == ASFO_OP_WORD_SHR;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Writes land on the edge where the master sees ack, never earlier
  assign req_hit = wb_req.cyc && wb_req.stb;
  assign wr_take = req_hit && wb_req.we && r_reg.ack;
  assign start_op = asfo_op_t'(wb_req.wdata[ASFO_CMD_OP_LSB +: 4]);
  assign start_mode = asfo_mode_t'(wb_req.wdata[ASFO_CMD_MODE_LSB +: 2]);
  assign op_ok = wb_req.wdata[ASFO_CMD_OP_LSB +: 4] <= ASFO_OP_STACK_FLOW;
  // A command while busy, or with an unused code, is dropped
  assign start = wr_take && wb_req.adr == ASFO_OFS_CMD && wb_req.sel[0] &&
                 !t_busy && op_ok;
  assign start_step = is_word(start_op) ? ASFO_STEP_WORD : ASFO_STEP_BYTE;
  assign step_w = is_word(r_reg.op) ? ASFO_STEP_WORD : ASFO_STEP_BYTE;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  assign sub_w = {1'b0, r_reg.dst} - {1'b0, r_reg.src} - {16'h0000, r_reg.flags.c};
  assign tcm_w = ~r_reg.dst[7:0] & r_reg.src[7:0];

  asfo_arith_shifter #(.W(8)) u_shift_byte (
    .operand(r_reg.dst[7:0]),
    .right(r_reg.op == ASFO_OP_BYTE_SHR),
    .result(sh8_res),
    .carry(sh8_c),
    .ovf(sh8_v)
  );

  asfo_arith_shifter #(.W(16)) u_shift_word (
    .operand(r_reg.dst),
    .right(r_reg.op == ASFO_OP_WORD_SHR),
    .result(sh16_res),
    .carry(sh16_c),
    .ovf(sh16_v)
  );

  asfo_cycle_timer u_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(start),
    .cycles(op_cycles(start_op)),
    .busy(t_busy),
    .last(t_last)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] m;
    m = ASFO_RST_BUS;
    r_next = r_reg;
    r_next.ack = req_hit && !r_reg.ack;
    r_next.done = 1'b0;
    if (req_hit && !r_reg.ack) begin
      unique case (wb_req.adr)
        ASFO_OFS_CMD: r_next.rdata = {26'h0, r_reg.mode, r_reg.op};
        ASFO_OFS_DST: r_next.rdata = {16'h0000, r_reg.dst};
        ASFO_OFS_SRC: r_next.rdata = {16'h0000, r_reg.src};
        ASFO_OFS_FLAGS: r_next.rdata = {25'h0, r_reg.flags};
        ASFO_OFS_PTRS: r_next.rdata = {r_reg.rp1, r_reg.rp0, r_reg.rp, r_reg.page};
        ASFO_OFS_PAIR: r_next.rdata = {16'h0000, r_reg.pair};
        ASFO_OFS_CTRL: r_next.rdata = {31'h0, r_reg.sp_in_rf};
        ASFO_OFS_STATUS: r_next.rdata = {r_reg.access_addr, 14'h0, access_data_space, t_busy};
        default: r_next.rdata = ASFO_RST_BUS;
      endcase
    end
    // Operand and state registers are frozen while an operation runs
    if (wr_take && !t_busy) begin
      unique case (wb_req.adr)
        ASFO_OFS_DST: begin
          m = lane_merge({16'h0000, r_reg.dst}, wb_req.wdata, wb_req.sel);
          r_next.dst = m[15:0];
        end
        ASFO_OFS_SRC: begin
          m = lane_merge({16'h0000, r_reg.src}, wb_req.wdata, wb_req.sel);
          r_next.src = m[15:0];
        end
        ASFO_OFS_FLAGS: begin
          m = lane_merge({25'h0, r_reg.flags}, wb_req.wdata, wb_req.sel);
          r_next.flags = asfo_flags_t'(m[6:0]);
        end
        ASFO_OFS_PAIR: begin
          m = lane_merge({16'h0000, r_reg.pair}, wb_req.wdata, wb_req.sel);
          r_next.pair = m[15:0];
        end
        ASFO_OFS_CTRL: begin
          if (wb_req.sel[0]) begin
            r_next.sp_in_rf = wb_req.wdata[0];
          end
        end
        default: begin
        end
      endcase
    end
    if (start) begin
      r_next.state = ASFO_RUN;
      r_next.op = start_op;
      r_next.mode = start_mode;
      r_next.stack_op = start_op == ASFO_OP_STACK_FLOW;
      r_next.access_addr = r_reg.pair;
      if (start_mode == ASFO_MODE_PREDEC) begin
        r_next.pair = r_reg.pair - start_step;
        r_next.access_addr = r_reg.pair - start_step;
      end
    end
    if (r_reg.state == ASFO_RUN && t_last) begin
      r_next.state = ASFO_IDLE;
      r_next.done = 1'b1;
      r_next.stack_op = 1'b0;
      if (r_reg.mode == ASFO_MODE_POSTINC) begin
        r_next.pair = r_reg.pair + step_w;
      end
      // D and H are left alone wherever their outcome is undefined
      unique case (r_reg.op)
        ASFO_OP_WORD_SUB_BORROW: begin
          r_next.dst = sub_w[15:0];
          r_next.flags.c = sub_w[16];
          r_next.flags.z = sub_w[15:0] == ASFO_RST_WORD;
          r_next.flags.s = sub_w[15];
          r_next.flags.v = (r_reg.dst[15] ^ r_reg.src[15]) & (r_reg.dst[15] ^ sub_w[15]);
        end
        ASFO_OP_CARRY_SET: r_next.flags.c = 1'b1;
        ASFO_OP_SEL_DATA: r_next.flags.dp = 1'b1;
        ASFO_OP_SEL_PROG: r_next.flags.dp = 1'b0;
        ASFO_OP_BYTE_SHL, ASFO_OP_BYTE_SHR: begin
          r_next.dst[7:0] = sh8_res;
          r_next.flags.c = sh8_c;
          r_next.flags.z = sh8_res == ASFO_RST_BYTE;
          r_next.flags.s = sh8_res[7];
          r_next.flags.v = sh8_v;
          r_next.flags.d = 1'b0;
        end
        ASFO_OP_WORD_SHL, ASFO_OP_WORD_SHR: begin
          r_next.dst = sh16_res;
          r_next.flags.c = sh16_c;
          r_next.flags.z = sh16_res == ASFO_RST_WORD;
          r_next.flags.s = sh16_res[15];
          r_next.flags.v = sh16_v;
        end
        ASFO_OP_LOAD_PAGE: r_next.page = r_reg.src[7:0];
        ASFO_OP_LOAD_WORKING: r_next.rp = r_reg.src[7:0];
        ASFO_OP_LOAD_PTR0: r_next.rp0 = r_reg.src[7:0];
        ASFO_OP_LOAD_PTR1: r_next.rp1 = r_reg.src[7:0];
        ASFO_OP_TEST_COMPL: begin
          r_next.flags.z = tcm_w == ASFO_RST_BYTE;
          r_next.flags.s = tcm_w[7];
          r_next.flags.v = 1'b0;
        end
        ASFO_OP_STACK_FLOW: begin
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_rdata = r_reg.rdata;
  assign wb_ack = r_reg.ack;
  assign space_select_flag = r_reg.flags.dp;
  // Stack traffic in the register file follows the space flag as normal
  assign access_data_space = (r_reg.stack_op && !r_reg.sp_in_rf) || r_reg.flags.dp;
  assign access_addr = r_reg.access_addr;
  assign page_pointer = r_reg.page;
  assign busy = t_busy;
  assign done = r_reg.done;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic [5:0] flags_hi;
  logic [1:0] flags_dh;
  logic [7:0] exp_shl8;
  logic [7:0] exp_shr8;
  logic [15:0] exp_shl16;
  logic [15:0] exp_shr16;
  logic [15:0] exp_pair_dec;
  assign flags_hi = r_reg.flags[6:1];
  assign flags_dh = {r_reg.flags.h, r_reg.flags.d};
  assign exp_shl8 = {r_reg.dst[6:0], 1'b0};
  assign exp_shr8 = {r_reg.dst[7], r_reg.dst[7:1]};
  assign exp_shl16 = {r_reg.dst[14:0], 1'b0};
  assign exp_shr16 = {r_reg.dst[15], r_reg.dst[15:1]};
  assign exp_pair_dec = r_reg.pair - start_step;

  sequence s_short_run;
    ##1 t_busy [*6] ##1 !t_busy;
  endsequence

  sequence s_done_after_six;
    ##7 done ##1 !done;
  endsequence

  word_sub_result_a: assert property (
    start && start_op == ASFO_OP_WORD_SUB_BORROW |-> ##11
      (r_reg.dst == $past(sub_w[15:0], 11) && r_reg.flags.c == $past(sub_w[16], 11) &&
       flags_dh == $past(flags_dh, 11)))
    else $error("word subtract result or flags wrong");
  undefined_flags_kept_a: assert property (
    start && start_op == ASFO_OP_WORD_SHL |-> ##11 flags_dh == $past(flags_dh, 11))
    else $error("undefined flags were changed");
  carry_set_time_a: assert property (
    start && start_op == ASFO_OP_CARRY_SET |-> s_short_run and s_done_after_six)
    else $error("carry set did not take six cycles");
  carry_set_flags_a: assert property (
    start && start_op == ASFO_OP_CARRY_SET |-> ##7
      (r_reg.flags.c && flags_hi == $past(flags_hi, 7)))
    else $error("carry set changed other flags");
  data_space_a: assert property (
    start && start_op == ASFO_OP_SEL_DATA |-> ##7 space_select_flag && access_data_space)
    else $error("data space not selected");
  prog_space_a: assert property (
    start && start_op == ASFO_OP_SEL_PROG |-> ##7 !space_select_flag)
    else $error("program space not selected");
  stack_space_a: assert property (
    start && start_op == ASFO_OP_STACK_FLOW && !r_reg.sp_in_rf |=>
      access_data_space throughout ##9 t_last)
    else $error("stack access left data space");
  byte_shl_a: assert property (
    start && start_op == ASFO_OP_BYTE_SHL |-> ##7
      (r_reg.dst[7:0] == $past(exp_shl8, 7) && !r_reg.flags.d))
    else $error("byte left shift wrong");
  word_shl_a: assert property (
    start && start_op == ASFO_OP_WORD_SHL |-> ##11 r_reg.dst == $past(exp_shl16, 11))
    else $error("word left shift wrong");
  byte_shr_a: assert property (
    start && start_op == ASFO_OP_BYTE_SHR |-> ##7
      (r_reg.dst[7:0] == $past(exp_shr8, 7) && !r_reg.flags.d))
    else $error("byte right shift wrong");
  word_shr_a: assert property (
    start && start_op == ASFO_OP_WORD_SHR |-> ##7
      (r_reg.dst == $past(exp_shr16, 7) && !r_reg.flags.v))
    else $error("word right shift wrong");
  page_load_a: assert property (
    start && start_op == ASFO_OP_LOAD_PAGE |-> ##7
      (page_pointer == $past(r_reg.src[7:0], 7) && flags_hi == $past(flags_hi, 7)))
    else $error("page pointer not loaded");
  working_load_a: assert property (
    start && start_op == ASFO_OP_LOAD_WORKING |-> ##7 r_reg.rp == $past(r_reg.src[7:0], 7))
    else $error("working pointer not loaded");
  ptr_one_load_a: assert property (
    start && start_op == ASFO_OP_LOAD_PTR1 |-> ##7
      (r_reg.rp1 == $past(r_reg.src[7:0], 7) && r_reg.rp0 == $past(r_reg.rp0, 7)))
    else $error("pointer one load wrong");
  test_compl_a: assert property (
    start && start_op == ASFO_OP_TEST_COMPL |-> ##7
      (r_reg.dst == $past(r_reg.dst, 7) && r_reg.flags.z == ($past(tcm_w, 7) == 8'h00)))
    else $error("test and complement wrong");
  pair_predec_a: assert property (
    start && start_mode == ASFO_MODE_PREDEC |=> r_reg.pair == $past(exp_pair_dec))
    else $error("pre-decrement step wrong");
  bus_ack_a: assert property (
    req_hit && !wb_ack |=> wb_ack ##1 !wb_ack)
    else $error("bus answer timing wrong");

endmodule
`default_nettype wire

/* rtl/asfo_pkg.sv */
// Shared constants, enumerations and carriers for the arithmetic, shift and flag unit.
// Assumes one 20 MHz core clock and a classic Wishbone register port with 32-bit data.
package asfo_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ASFO_OFS_CMD = 8'h00;
  localparam logic [7:0] ASFO_OFS_DST = 8'h04;
  localparam logic [7:0] ASFO_OFS_SRC = 8'h08;
  localparam logic [7:0] ASFO_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] ASFO_OFS_PTRS = 8'h10;
  localparam logic [7:0] ASFO_OFS_PAIR = 8'h14;
  localparam logic [7:0] ASFO_OFS_CTRL = 8'h18;
  localparam logic [7:0] ASFO_OFS_STATUS = 8'h1c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ASFO_CMD_OP_LSB = 0;
  localparam int ASFO_CMD_MODE_LSB = 4;
  localparam logic [15:0] ASFO_RST_WORD = 16'h0000;
  localparam logic [7:0] ASFO_RST_BYTE = 8'h00;
  localparam logic [31:0] ASFO_RST_BUS = 32'h0000_0000;
  localparam logic [15:0] ASFO_STEP_BYTE = 16'h0001;
  localparam logic [15:0] ASFO_STEP_WORD = 16'h0002;

  // ----------------------------------------
  // Timing in core clock cycles
  // ----------------------------------------
  localparam logic [5:0] ASFO_CYC_WORD_SUB = 6'h0a;
  localparam logic [5:0] ASFO_CYC_WORD_SHL = 6'h0a;
  localparam logic [5:0] ASFO_CYC_STACK = 6'h0a;
  localparam logic [5:0] ASFO_CYC_SHORT = 6'h06;
  localparam logic [5:0] ASFO_CNT_ZERO = 6'h00;
  localparam logic [5:0] ASFO_CNT_ONE = 6'h01;

  typedef enum logic [3:0] {
    ASFO_OP_WORD_SUB_BORROW = 4'h0,
    ASFO_OP_CARRY_SET = 4'h1,
    ASFO_OP_SEL_DATA = 4'h2,
    ASFO_OP_SEL_PROG = 4'h3,
    ASFO_OP_BYTE_SHL = 4'h4,
    ASFO_OP_WORD_SHL = 4'h5,
    ASFO_OP_BYTE_SHR = 4'h6,
    ASFO_OP_WORD_SHR = 4'h7,
    ASFO_OP_LOAD_PAGE = 4'h8,
    ASFO_OP_LOAD_WORKING = 4'h9,
    ASFO_OP_LOAD_PTR0 = 4'ha,
    ASFO_OP_LOAD_PTR1 = 4'hb,
    ASFO_OP_TEST_COMPL = 4'hc,
    ASFO_OP_STACK_FLOW = 4'hd
  } asfo_op_t;

  typedef enum logic [1:0] {
    ASFO_MODE_NONE = 2'b00,
    ASFO_MODE_POSTINC = 2'b01,
    ASFO_MODE_PREDEC = 2'b10
  } asfo_mode_t;

  typedef enum logic [0:0] {
    ASFO_IDLE = 1'b0,
    ASFO_RUN = 1'b1
  } asfo_state_t;

  // Carry is bit 0 of the flag register
  typedef struct packed {
    logic dp;
    logic h;
    logic d;
    logic v;
    logic s;
    logic z;
    logic c;
  } asfo_flags_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdata;
  } asfo_wb_req_t;

  typedef struct packed {
    logic running;
    logic [5:0] cnt;
  } asfo_timer_t;

  typedef struct packed {
    asfo_state_t state;
    asfo_op_t op;
    asfo_mode_t mode;
    logic [15:0] dst;
    logic [15:0] src;
    asfo_flags_t flags;
    logic [7:0] page;
    logic [7:0] rp;
    logic [7:0] rp0;
    logic [7:0] rp1;
    logic [15:0] pair;
    logic sp_in_rf;
    logic [15:0] access_addr;
    logic stack_op;
    logic ack;
    logic [31:0] rdata;
    logic done;
  } asfo_core_t;

endpackage

/* rtl/asfo_arith_shifter.sv */
// One-place arithmetic shifter, left or right, for any operand width of two bits or more.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module asfo_arith_shifter #(
  parameter int W = 8
) (
  input wire logic [W-1:0] operand,
  input wire logic right,
  output logic [W-1:0] result,
  output logic carry,
  output logic ovf
);

  // ----------------------------------------
  // Shift
  // ----------------------------------------
  always_comb begin
    if (right) begin
      // Sign bit stays, so the result can never overflow
      result = {operand[W-1], operand[W-1:1]};
      carry = operand[0];
      ovf = 1'b0;
    end else begin
      result = {operand[W-2:0], 1'b0};
      carry = operand[W-1];
      ovf = operand[W-1] ^ operand[W-2];
    end
  end

endmodule
`default_nettype wire

/* rtl/asfo_cycle_timer.sv */
// Execution timer: holds busy for the programmed number of core cycles.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`default_nettype none
module asfo_cycle_timer import asfo_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [5:0] cycles,
  output logic busy,
  output logic last
);

  asfo_timer_t t_reg;
  asfo_timer_t t_next;

  // ----------------------------------------
  // Count down
  // ----------------------------------------
  always_comb begin
    t_next = t_reg;
    if (start) begin
      t_next.running = 1'b1;
      t_next.cnt = cycles - ASFO_CNT_ONE;
    end else if (t_reg.running && t_reg.cnt == ASFO_CNT_ZERO) begin
      t_next.running = 1'b0;
    end else if (t_reg.running) begin
      t_next.cnt = t_reg.cnt - ASFO_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign busy = t_reg.running;
  assign last = t_reg.running && (t_reg.cnt == ASFO_CNT_ZERO);

  timer_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start |=> busy && t_reg.cnt == $past(cycles) - ASFO_CNT_ONE)
    else $error("timer did not load the cycle count");

endmodule
`default_nettype wire

/* sim/arith_shift_flag_ops_tb.sv */
// Self-checking bench for the arithmetic, shift and flag unit.
// Assumes asfo_core alone, driven over classic Wishbone on one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module arith_shift_flag_ops_tb import asfo_pkg::*;;
  logic ref_clk;
  logic arst_n;
  asfo_wb_req_t wb_req;
  logic [31:0] wb_rdata;
  logic wb_ack;
  logic space_select_flag;
  logic access_data_space;
  logic [15:0] access_addr;
  logic [7:0] page_pointer;
  logic busy;
  logic done;
  int n_fail;
  int cmp_count;
  logic [31:0] rd;
  logic [15:0] got_addr;
  logic got_sp;

  asfo_core u_dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wb_req(wb_req),
    .wb_rdata(wb_rdata),
    .wb_ack(wb_ack),
    .space_select_flag(space_select_flag),
    .access_data_space(access_data_space),
    .access_addr(access_addr),
    .page_pointer(page_pointer),
    .busy(busy),
    .done(done)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Wishbone classic single cycles
  // ----------------------------------------
  // Request held until ack is sampled; released at that same edge
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, wdata: d};
    // No wait limit here; a dead slave is caught by the watchdog
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    r = wb_rdata;
    wb_req <= '0;
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb_xfer(1'b1, a, d, dummy);
  endtask

  task automatic wb_read(input logic [7:0] a, output logic [31:0] r);
    wb_xfer(1'b0, a, 32'h0000_0000, r);
  endtask

  // Start an op, count busy cycles, then expect the done pulse
  task automatic run(input logic [3:0] op, input logic [1:0] md, input logic [5:0] n);
    int k;
    k = 0;
    wb_write(ASFO_OFS_CMD, {26'h0, md, op});
    @(negedge ref_clk);
    got_addr = access_addr;
    got_sp = access_data_space;
    while (busy === 1'b1 && k < 64) begin
      k++;
      @(negedge ref_clk);
    end
    chk(32'(k), {26'h0, n});
    chk({31'h0, done}, 32'h0000_0001);
  endtask

  // Load operands and flags, run, then check result and flags
  task automatic alu(input logic [3:0] op, input logic [15:0] d, input logic [15:0] s,
                     input logic [6:0] f, input logic [15:0] ed, input logic [6:0] ef,
                     input logic [5:0] n);
    wb_write(ASFO_OFS_DST, {16'h0, d});
    wb_write(ASFO_OFS_SRC, {16'h0, s});
    wb_write(ASFO_OFS_FLAGS, {25'h0, f});
    run(op, 2'h0, n);
    wb_read(ASFO_OFS_DST, rd);
    chk(rd, {16'h0, ed});
    wb_read(ASFO_OFS_FLAGS, rd);
    chk(rd, {25'h0, ef});
  endtask

  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    wb_req = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    wb_read(ASFO_OFS_FLAGS, rd);
    chk(rd, 32'h0000_0000);
    wb_read(8'h20, rd);
    chk(rd, 32'h0000_0000);
    tdone("reset_and_unmapped");
    // Borrow in, borrow out, signed overflow; D and H kept
    alu(4'h0, 16'h1234, 16'h0234, 7'h31, 16'h0fff, 7'h30, 6'h0a);
    alu(4'h0, 16'h0000, 16'h0000, 7'h01, 16'hffff, 7'h05, 6'h0a);
    alu(4'h0, 16'h8000, 16'h0001, 7'h00, 16'h7fff, 7'h08, 6'h0a);
    tdone("word_subtract");
    alu(4'h1, 16'h5555, 16'h0000, 7'h7e, 16'h5555, 7'h7f, 6'h06);
    tdone("carry_set");
    alu(4'h2, 16'h0000, 16'h0000, 7'h00, 16'h0000, 7'h40, 6'h06);
    chk({31'h0, space_select_flag}, 32'h0000_0001);
    chk({31'h0, access_data_space}, 32'h0000_0001);
    alu(4'h3, 16'h0000, 16'h0000, 7'h7f, 16'h0000, 7'h3f, 6'h06);
    chk({31'h0, space_select_flag}, 32'h0000_0000);
    chk({31'h0, access_data_space}, 32'h0000_0000);
    tdone("space_select");
    // Byte shifts leave the high byte alone
    alu(4'h4, 16'h12c1, 16'h0000, 7'h30, 16'h1282, 7'h25, 6'h06);
    alu(4'h5, 16'h8001, 16'h0000, 7'h00, 16'h0002, 7'h09, 6'h0a);
    alu(4'h6, 16'hab81, 16'h0000, 7'h18, 16'habc0, 7'h05, 6'h06);
    alu(4'h7, 16'h8003, 16'h0000, 7'h08, 16'hc001, 7'h05, 6'h06);
    tdone("shifts");
    alu(4'hc, 16'h55f0, 16'h0f0f, 7'h0b, 16'h55f0, 7'h01, 6'h06);
    alu(4'hc, 16'h00ff, 16'h00ff, 7'h0c, 16'h00ff, 7'h02, 6'h06);
    tdone("test_complement");
    alu(4'h8, 16'h0000, 16'h00a5, 7'h15, 16'h0000, 7'h15, 6'h06);
    chk({24'h0, page_pointer}, 32'h0000_00a5);
    alu(4'h9, 16'h0000, 16'h003c, 7'h2a, 16'h0000, 7'h2a, 6'h06);
    alu(4'ha, 16'h0000, 16'h005a, 7'h0f, 16'h0000, 7'h0f, 6'h06);
    alu(4'hb, 16'h0000, 16'h00c3, 7'h30, 16'h0000, 7'h30, 6'h06);
    wb_write(ASFO_OFS_PTRS, 32'hffff_ffff);
    wb_read(ASFO_OFS_PTRS, rd);
    chk(rd, 32'hc35a_3ca5);
    tdone("pointer_loads");
    // Word post-increment, then byte pre-decrement
    wb_write(ASFO_OFS_PAIR, 32'h0000_1000);
    run(4'h0, 2'h1, 6'h0a);
    chk({16'h0, got_addr}, 32'h0000_1000);
    wb_read(ASFO_OFS_PAIR, rd);
    chk(rd, 32'h0000_1002);
    run(4'h4, 2'h2, 6'h06);
    chk({16'h0, got_addr}, 32'h0000_1001);
    wb_read(ASFO_OFS_PAIR, rd);
    chk(rd, 32'h0000_1001);
    tdone("pair_stepping");
    // Stack access in program-space mode, stack outside then inside registers
    wb_write(ASFO_OFS_CTRL, 32'h0000_0000);
    run(4'hd, 2'h0, 6'h0a);
    chk({31'h0, got_sp}, 32'h0000_0001);
    wb_write(ASFO_OFS_CTRL, 32'h0000_0001);
    run(4'hd, 2'h0, 6'h0a);
    chk({31'h0, got_sp}, 32'h0000_0000);
    tdone("stack_space");
    // Unused op code must not start anything
    wb_write(ASFO_OFS_CMD, 32'h0000_000e);
    @(negedge ref_clk);
    chk({31'h0, busy}, 32'h0000_0000);
    tdone("unused_op");
    end_of_test();
  end
endmodule
`default_nettype wire
